//--- inc/asi_pkg.sv
// Shared constants and types of the asynchronous serial interface
package asi_pkg;

  // ==========================================================================
  // Register map (byte addresses on the Wishbone bus)
  localparam logic [7:0] ADR_DATA  = 8'h00;
  localparam logic [7:0] ADR_CTRL1 = 8'h04;
  localparam logic [7:0] ADR_CTRL2 = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0c;
  localparam logic [7:0] ADR_BAUD  = 8'h10;

  // ==========================================================================
  // Control one fields
  localparam int C1_RX_BIT8   = 7;
  localparam int C1_TX_BIT8   = 6;
  localparam int C1_NINE_BITS = 4;
  localparam int C1_WAKE_ADDR = 3;

  // ==========================================================================
  // Control two fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_COMPL_IE = 6;
  localparam int C2_RX_IE       = 5;
  localparam int C2_IDLE_IE     = 4;
  localparam int C2_TX_EN       = 3;
  localparam int C2_RX_EN       = 2;
  localparam int C2_SLEEP       = 1;
  localparam int C2_BREAK       = 0;

  // ==========================================================================
  // Status fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_COMPL = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [4:0] BAUD_RESET  = 5'h00;
  localparam logic       TX_EMPTY_RESET = 1'b1;
  localparam logic       TX_COMPL_RESET = 1'b1;

  // ==========================================================================
  // Timing
  localparam int         CLK_HZ          = 40_000_000;
  localparam logic [3:0] FRAME_LEN_EIGHT = 4'ha;
  localparam logic [3:0] FRAME_LEN_NINE  = 4'hb;
  // Oversample tick positions within a bit, counted from zero (tick n is RT n+1)
  localparam logic [3:0] RT_VERIFY_A = 4'h2;
  localparam logic [3:0] RT_VERIFY_B = 4'h4;
  localparam logic [3:0] RT_VERIFY_C = 4'h6;
  localparam logic [3:0] RT_SAMPLE_A = 4'h7;
  localparam logic [3:0] RT_SAMPLE_C = 4'h9;
  localparam logic [3:0] RT_LAST     = 4'hf;
  // Prescaler choices; with the 3-bit shift they give 32 rates
  localparam logic [11:0] PRE_0 = 12'h001;
  localparam logic [11:0] PRE_1 = 12'h003;
  localparam logic [11:0] PRE_2 = 12'h004;
  localparam logic [11:0] PRE_3 = 12'h00d;

  typedef enum {RX_HUNT, RX_FRAME} asi_rx_state_type;

  // Clock cycles per oversample tick for a 5-bit rate select
  function automatic logic [11:0] asi_rate_div(input logic [4:0] sel);
    logic [11:0] pre;
    case (sel[4:3])
      2'h0:    pre = PRE_0;
      2'h1:    pre = PRE_1;
      2'h2:    pre = PRE_2;
      default: pre = PRE_3;
    endcase
    return pre << sel[2:0];
  endfunction : asi_rate_div

  // Two out of three vote
  function automatic logic asi_vote(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : asi_vote

endpackage : asi_pkg

//--- rtl/asi_baud_gen.sv
// Shared rate generator: oversample tick and transmit bit tick
`timescale 1ns/10ps
`default_nettype none
module asi_baud_gen
  import asi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [4:0] rate_sel,
  output var  logic       os_tick,
  output var  logic       bit_tick
);

  logic [11:0] div_cnt_q;
  logic [3:0]  os_cnt_q;
  logic [11:0] div_last;

  assign div_last = asi_rate_div(rate_sel) - 12'h001;

  // ==========================================================================
  // Divider; a rate change mid-count wraps at once rather than stalling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 12'h000;
      os_tick   <= 1'b0;
    end else if (div_cnt_q >= div_last) begin
      div_cnt_q <= 12'h000;
      os_tick   <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
      os_tick   <= 1'b0;
    end
  end

  // ==========================================================================
  // Transmit bit clock is one sixteenth of the oversample clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      os_cnt_q <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (os_tick) begin
        os_cnt_q <= os_cnt_q + 4'h1;
        bit_tick <= (os_cnt_q == RT_LAST);
      end
    end
  end

endmodule : asi_baud_gen
`default_nettype wire

//--- rtl/asi_top.sv
// Asynchronous serial interface: Wishbone registers, transmitter and receiver
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Tx and Rx share one 32-rate generator
// - Eight or nine data bits, both directions
// - Data write sends; load sets tx empty
// - Load on bit clock, LSB first
// - Tx complete when nothing left to send
// - Tx complete also once disabled and drained
// - Disable never truncates the current character
// - Data address: write tx, read rx
// - Received byte moves, sets rx full
// - Overrun, noise and framing error flags
// - Idle flag only after a received character, errors or not
// - Idle high, start low, data, stop high
// - Full low frame is a break
// - Sleeping receiver blocks all receive flags except those of the waking address character
// - Wake clears sleep; software may too
// - Idle wake after 10 or 11 high bits
// - Address mark character wakes sleeping receiver
// - Sixteen-times sampling, resync on start bit
// - Vote of samples eight, nine, ten
// - Noise when the three samples differ
// - Start accepted on two of three lows
// - Enabling transmitter sends preamble of ones
module asi_top
  import asi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        serial_rx_line,
  output var  logic        serial_tx_line,
  output var  logic        serial_tx_oe,
  output var  logic        irq
);

  // ==========================================================================
  // Declarations
  logic        ack_q, acc, wr, rd;
  logic        wr_data, wr_ctrl1, wr_ctrl2, rd_data, rd_stat;
  logic [31:0] dat_q;
  logic        os_tick, bit_tick;
  logic [4:0]  baud_q;
  logic        t8_q, nine_q, wake_addr_q;
  logic        tie_q, tx_complete_irq_enable_q, rie_q, ilie_q, te_q, re_q, sleep_q, sbk_q;
  logic        tx_empty_flag_q, tc_q, rxf_q, idle_q, ovr_q, nf_q, fe_q, irq_q;
  logic [7:0]  arm_q;
  logic [7:0]  status;
  logic [3:0]  frame_len;
  // Transmitter
  logic [7:0]  tx_hold_q;
  logic        tx_pend_q, pre_pend_q, tx_line_q, tx_oe_q;
  logic [10:0] tx_shift_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_done, tx_load_pre, tx_load_brk, tx_load_data, tc_set;
  logic [10:0] tx_frame;
  // Receiver
  logic              rx_m_q, rx_s_q;
  asi_rx_state_type  rx_state_q;
  logic [3:0]  rt_q, bit_idx_q;
  logic [2:0]  samp_q;
  logic [1:0]  ver_q;
  logic        nz_q, seen_high_q, char_seen_q;
  logic [8:0]  rx_shift_q;
  logic [7:0]  rx_data_q, idle_cnt_q;
  logic        r8_q;
  logic [2:0]  samp_now;
  logic        vote, noisy, at_vote, frame_done, awake, addr_wake, idle_hit, idle_wake;
  logic        rxf_set, ovr_set, nf_set, fe_set, idle_set;
  logic [1:0]  ver_lows;

  assign frame_len = nine_q ? FRAME_LEN_NINE : FRAME_LEN_EIGHT;

  // ==========================================================================
  // Wishbone slave: one wait state, ack for exactly one cycle
  assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = acc & wb_we_i & wb_sel_i[0];
  assign rd       = acc & ~wb_we_i;
  assign wr_data  = wr & (wb_adr_i == ADR_DATA);
  assign wr_ctrl1 = wr & (wb_adr_i == ADR_CTRL1);
  assign wr_ctrl2 = wr & (wb_adr_i == ADR_CTRL2);
  assign rd_data  = rd & (wb_adr_i == ADR_DATA);
  assign rd_stat  = rd & (wb_adr_i == ADR_STAT);

  assign status = {tx_empty_flag_q, tc_q, rxf_q, idle_q, ovr_q, nf_q, fe_q, 1'b0};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (rd) begin
        case (wb_adr_i)
          ADR_DATA:  dat_q <= {24'h00_0000, re_q ? rx_data_q : 8'h00};
          ADR_CTRL1: dat_q <= {24'h00_0000, r8_q, t8_q, 1'b0, nine_q, wake_addr_q, 3'h0};
          ADR_CTRL2: dat_q <= {24'h00_0000, tie_q, tx_complete_irq_enable_q, rie_q, ilie_q,
                               te_q, re_q, sleep_q, sbk_q};
          ADR_STAT:  dat_q <= {24'h00_0000, status};
          ADR_BAUD:  dat_q <= {27'h000_0000, baud_q};
          default:   dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign serial_tx_line = tx_line_q;
  assign serial_tx_oe   = tx_oe_q;
  assign irq            = irq_q;

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t8_q        <= CTRL1_RESET[C1_TX_BIT8];
      nine_q      <= CTRL1_RESET[C1_NINE_BITS];
      wake_addr_q <= CTRL1_RESET[C1_WAKE_ADDR];
      baud_q      <= BAUD_RESET;
    end else begin
      if (wr_ctrl1) begin
        t8_q        <= wb_dat_i[C1_TX_BIT8];
        nine_q      <= wb_dat_i[C1_NINE_BITS];
        wake_addr_q <= wb_dat_i[C1_WAKE_ADDR];
      end
      if (wr & (wb_adr_i == ADR_BAUD)) begin
        baud_q <= wb_dat_i[4:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tie_q   <= CTRL2_RESET[C2_TX_EMPTY_IE];
      tx_complete_irq_enable_q  <= CTRL2_RESET[C2_TX_COMPL_IE];
      rie_q   <= CTRL2_RESET[C2_RX_IE];
      ilie_q  <= CTRL2_RESET[C2_IDLE_IE];
      te_q    <= CTRL2_RESET[C2_TX_EN];
      re_q    <= CTRL2_RESET[C2_RX_EN];
      sleep_q <= CTRL2_RESET[C2_SLEEP];
      sbk_q   <= CTRL2_RESET[C2_BREAK];
    end else if (wr_ctrl2) begin
      // A software write outranks a wake in the same cycle
      tie_q   <= wb_dat_i[C2_TX_EMPTY_IE];
      tx_complete_irq_enable_q  <= wb_dat_i[C2_TX_COMPL_IE];
      rie_q   <= wb_dat_i[C2_RX_IE];
      ilie_q  <= wb_dat_i[C2_IDLE_IE];
      te_q    <= wb_dat_i[C2_TX_EN];
      re_q    <= wb_dat_i[C2_RX_EN];
      sleep_q <= wb_dat_i[C2_SLEEP];
      sbk_q   <= wb_dat_i[C2_BREAK];
    end else if (addr_wake | idle_wake) begin
      sleep_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Rate generator shared by both directions
  asi_baud_gen u_baud (
    .clk      (clk),
    .rst_b    (rst_b),
    .rate_sel (baud_q),
    .os_tick  (os_tick),
    .bit_tick (bit_tick)
  );

  // ==========================================================================
  // Transmitter. The line register always holds the bit now on the wire,
  // so a new frame follows the last one with no gap.
  assign tx_frame     = nine_q ? {1'b1, t8_q, tx_hold_q, 1'b0}
                               : {2'b11, tx_hold_q, 1'b0};
  assign tx_done      = bit_tick & (tx_cnt_q <= 4'h1);
  assign tx_load_pre  = tx_done & te_q & pre_pend_q;
  assign tx_load_brk  = tx_done & te_q & ~pre_pend_q & sbk_q;
  assign tx_load_data = tx_done & te_q & ~pre_pend_q & ~sbk_q & tx_pend_q;
  assign tc_set       = tx_done & ~tx_load_pre & ~tx_load_brk & ~tx_load_data;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_hold_q  <= 8'h00;
      tx_pend_q  <= 1'b0;
      pre_pend_q <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_hold_q <= wb_dat_i[7:0];
      end
      tx_pend_q <= wr_data | (tx_pend_q & ~tx_load_data);
      if (wr_ctrl2 & wb_dat_i[C2_TX_EN] & ~te_q) begin
        pre_pend_q <= 1'b1;
      end else if (tx_load_pre) begin
        pre_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_q <= 11'h7ff;
      tx_cnt_q   <= 4'h0;
      tx_line_q  <= 1'b1;
      tx_oe_q    <= 1'b0;
    end else begin
      tx_oe_q <= te_q | (tx_cnt_q != 4'h0);
      if (tx_load_pre | tx_load_brk | tx_load_data) begin
        tx_cnt_q <= frame_len;
        if (tx_load_data) begin
          tx_line_q  <= tx_frame[0];
          tx_shift_q <= {1'b1, tx_frame[10:1]};
        end else begin
          tx_line_q  <= tx_load_pre;
          tx_shift_q <= tx_load_pre ? 11'h7ff : 11'h000;
        end
      end else if (tx_done) begin
        tx_cnt_q  <= 4'h0;
        tx_line_q <= 1'b1;
      end else if (bit_tick & (tx_cnt_q != 4'h0)) begin
        tx_cnt_q   <= tx_cnt_q - 4'h1;
        tx_line_q  <= tx_shift_q[0];
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      end
    end
  end

  // ==========================================================================
  // Receiver input synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= serial_rx_line;
      rx_s_q <= rx_m_q;
    end
  end

  // ==========================================================================
  // Receiver decisions
  assign samp_now   = {samp_q[1:0], rx_s_q};
  assign vote       = asi_vote(samp_now);
  assign noisy      = (samp_now != 3'h0) & (samp_now != 3'h7);
  assign ver_lows   = ver_q + {1'b0, ~rx_s_q};
  assign at_vote    = os_tick & (rx_state_q == RX_FRAME) & (rt_q == RT_SAMPLE_C);
  assign frame_done = at_vote & (bit_idx_q == frame_len - 4'h1);
  assign addr_wake  = frame_done & sleep_q & wake_addr_q & rx_shift_q[8];
  assign awake      = ~sleep_q | addr_wake;
  assign idle_hit   = os_tick & re_q & (rx_state_q == RX_HUNT) & rx_s_q &
                      (idle_cnt_q == {frame_len, 4'h0} - 8'h01);
  assign idle_wake  = idle_hit & sleep_q & ~wake_addr_q;
  assign rxf_set    = frame_done & awake & ~rxf_q;
  assign ovr_set    = frame_done & awake & rxf_q;
  assign nf_set     = frame_done & awake & (nz_q | noisy);
  assign fe_set     = frame_done & awake & ~vote;
  assign idle_set   = idle_hit & ~sleep_q & char_seen_q;

  // ==========================================================================
  // Receiver sequencer, resynchronised on every start edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_q  <= RX_HUNT;
      rt_q        <= 4'h0;
      bit_idx_q   <= 4'h0;
      samp_q      <= 3'h7;
      ver_q       <= 2'h0;
      nz_q        <= 1'b0;
      seen_high_q <= 1'b0;
      rx_shift_q  <= 9'h000;
    end else if (!re_q) begin
      rx_state_q <= RX_HUNT;
    end else if (os_tick) begin
      case (rx_state_q)
        RX_HUNT: begin
          if (rx_s_q) begin
            seen_high_q <= 1'b1;
          end else if (seen_high_q) begin
            rx_state_q <= RX_FRAME;
            rt_q       <= 4'h1;
            bit_idx_q  <= 4'h0;
            ver_q      <= 2'h0;
            nz_q       <= 1'b0;
          end
        end
        RX_FRAME: begin
          rt_q <= rt_q + 4'h1;
          if (bit_idx_q == 4'h0 &&
              (rt_q == RT_VERIFY_A || rt_q == RT_VERIFY_B)) begin
            ver_q <= ver_lows;
          end
          if (bit_idx_q == 4'h0 && rt_q == RT_VERIFY_C) begin
            if (ver_lows < 2'h2) begin
              rx_state_q <= RX_HUNT;
            end
            if (ver_lows != 2'h3) begin
              nz_q <= 1'b1;
            end
          end
          if (rt_q >= RT_SAMPLE_A && rt_q < RT_SAMPLE_C) begin
            samp_q <= samp_now;
          end
          if (rt_q == RT_SAMPLE_C) begin
            nz_q <= nz_q | noisy;
            if (bit_idx_q == 4'h0 && vote) begin
              rx_state_q <= RX_HUNT;
            end else if (frame_done) begin
              rx_state_q <= RX_HUNT;
              // A break needs a high level before the next start counts
              seen_high_q <= vote | (rx_shift_q[8:1] != 8'h00) |
                             (nine_q & rx_shift_q[0]);
            end else if (bit_idx_q != 4'h0) begin
              rx_shift_q <= {vote, rx_shift_q[8:1]};
            end
          end
          if (rt_q == RT_LAST) begin
            bit_idx_q <= bit_idx_q + 4'h1;
          end
        end
        default: rx_state_q <= RX_HUNT;
      endcase
    end
  end

  // Idle line counter, counted in oversample ticks of continuous high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_q <= 8'h00;
    end else if (!re_q || rx_state_q != RX_HUNT || !rx_s_q) begin
      idle_cnt_q <= 8'h00;
    end else if (os_tick && !idle_hit && idle_cnt_q < {frame_len, 4'h0}) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end else if (idle_hit) begin
      idle_cnt_q <= {frame_len, 4'h0};
    end
  end

  // Receive data register; on overrun the older character is kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_q   <= 8'h00;
      r8_q        <= 1'b0;
      char_seen_q <= 1'b0;
    end else begin
      if (rxf_set) begin
        rx_data_q <= nine_q ? rx_shift_q[7:0] : rx_shift_q[8:1];
        r8_q      <= rx_shift_q[8];
      end
      if (frame_done & awake) begin
        char_seen_q <= 1'b1;
      end else if (idle_set) begin
        char_seen_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Status flags: read status while set, then touch the data register to
  // clear. A hardware set in the clearing cycle wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_empty_flag_q <= TX_EMPTY_RESET;
      tc_q   <= TX_COMPL_RESET;
      rxf_q  <= 1'b0;
      idle_q <= 1'b0;
      ovr_q  <= 1'b0;
      nf_q   <= 1'b0;
      fe_q   <= 1'b0;
      arm_q  <= 8'h00;
      irq_q  <= 1'b0;
    end else begin
      // An access uses up its arming, so a later flag needs a new status read
      if (rd_stat) begin
        arm_q <= status;
      end else begin
        if (wr_data) begin
          arm_q[ST_TX_EMPTY:ST_TX_COMPL] <= 2'h0;
        end
        if (rd_data) begin
          arm_q[ST_RX_FULL:ST_FRAMING] <= 5'h00;
        end
      end
      tx_empty_flag_q <= tx_load_data | (tx_empty_flag_q & ~(wr_data & arm_q[ST_TX_EMPTY]));
      tc_q   <= tc_set | (tc_q & ~(wr_data & arm_q[ST_TX_COMPL]));
      rxf_q  <= rxf_set | (rxf_q & ~(rd_data & arm_q[ST_RX_FULL]));
      idle_q <= idle_set | (idle_q & ~(rd_data & arm_q[ST_IDLE]));
      ovr_q  <= ovr_set | (ovr_q & ~(rd_data & arm_q[ST_OVERRUN]));
      nf_q   <= nf_set | (nf_q & ~(rd_data & arm_q[ST_NOISE]));
      fe_q   <= fe_set | (fe_q & ~(rd_data & arm_q[ST_FRAMING]));
      irq_q  <= (tie_q & tx_empty_flag_q) | (tx_complete_irq_enable_q & tc_q) |
                (re_q & rie_q & (rxf_q | ovr_q)) | (re_q & ilie_q & idle_q);
    end
  end

endmodule : asi_top
`default_nettype wire

//--- test/asi_top_properties.sv
// Port checks of the serial interface
`timescale 1ns/10ps
`default_nettype none
module asi_top_properties
  import asi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_tx_line,
  input wire logic        serial_tx_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence te_write;
    bus_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL2 && wb_dat_i[C2_TX_EN];
  endsequence
  a_ack_follows_req: assert property (bus_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ADR_BAUD |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_tx_idle_high: assert property (!serial_tx_oe |-> serial_tx_line)
    else $error("released tx line not high");
  a_oe_after_enable: assert property (te_write |-> ##[1:3] serial_tx_oe)
    else $error("tx not driven after enable");
  a_preamble_ones: assert property ($rose(serial_tx_oe) |-> serial_tx_line [*8])
    else $error("preamble not high");
  a_frame_not_cut: assert property (serial_tx_oe && !serial_tx_line |=> serial_tx_oe)
    else $error("tx released inside a frame");
endmodule : asi_top_properties
bind asi_top asi_top_properties u_asi_top_properties (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_tx_line, .serial_tx_oe);
`default_nettype wire

//--- test/asi_remote.sv
// Remote serial device model
`timescale 1ns/10ps
`default_nettype none
module asi_remote (
  input wire logic clk,
  input wire logic tx_line,
  output var logic rx_line
);
  localparam int BITC = 16;
  initial rx_line = 1'b1;
  // A long idle after each frame keeps any message boundary visible
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BITC) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (12 * BITC) @(posedge clk);
  endtask : send
  task automatic recv(output logic [7:0] d);
    int n;
    n = 0;
    d = 'x;
    while (tx_line !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n < 2000) begin
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITC) @(posedge clk);
        d[i] = tx_line;
      end
    end
  endtask : recv
endmodule : asi_remote
`default_nettype wire

//--- test/asi_top_test.sv
// Self-checking bench of the serial interface
`timescale 1ns/10ps
`default_nettype none
module asi_top_test;
  import asi_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} asi_row_type;
  logic        clk, rst_b, cyc, stb, we, ack, rx, tx, oe, irq;
  logic [7:0]  adr, rd, b;
  logic [31:0] wdat, rdat;
  int          num_errors = 0;
  int          checks = 0;
  // Last row returns to eight-bit frames, which the remote model sends
  asi_row_type rows[7] = '{'{ADR_STAT, 8'hff, 8'hc0}, '{ADR_CTRL1, 8'hd8, 8'h58},
    '{ADR_BAUD, 8'hff, 8'h1f}, '{ADR_BAUD, 8'h00, 8'h00}, '{8'h14, 8'hff, 8'h00},
    '{ADR_CTRL2, 8'h0c, 8'h0c}, '{ADR_CTRL1, 8'h00, 8'h00}};
  asi_top u_asi_top (.clk, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_rx_line(rx),
    .serial_tx_line(tx), .serial_tx_oe(oe), .irq(irq));
  asi_remote u_asi_remote (.clk, .tx_line(tx), .rx_line(rx));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      num_errors++;
    end
  endtask : check
  // Held until ack is seen; read data is taken at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      end_of_test();
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    {rst_b, cyc, stb, we, adr, wdat} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    check("tx_reset", 8'h01, {6'h0, oe, tx});
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      xfer(1'b0, rows[i].a, 8'h00);
      check("register", rows[i].e, rd);
    end
    $display("registers done");
    xfer(1'b1, ADR_DATA, 8'ha5);
    u_asi_remote.recv(b);
    check("tx_byte", 8'ha5, b);
    repeat (40) @(posedge clk);
    xfer(1'b0, ADR_STAT, 8'h00);
    check("tx_done", 8'hc0, rd & 8'hc0);
    u_asi_remote.send(8'h3c, 1'b1);
    xfer(1'b0, ADR_STAT, 8'h00);
    check("rx_full", 8'h20, rd & 8'h2e);
    xfer(1'b0, ADR_DATA, 8'h00);
    check("rx_byte", 8'h3c, rd);
    $display("transfer done");
    u_asi_remote.send(8'hff, 1'b0);
    u_asi_remote.send(8'h11, 1'b1);
    xfer(1'b0, ADR_STAT, 8'h00);
    check("rx_errors", 8'h2a, rd & 8'h2e);
    xfer(1'b0, ADR_DATA, 8'h00);
    check("rx_kept", 8'hff, rd);
    $display("errors done");
    xfer(1'b1, ADR_CTRL1, 8'h08);
    xfer(1'b1, ADR_CTRL2, 8'h0e);
    u_asi_remote.send(8'h22, 1'b1);
    xfer(1'b0, ADR_STAT, 8'h00);
    check("asleep", 8'h00, rd & 8'h2e);
    u_asi_remote.send(8'h81, 1'b1);
    xfer(1'b0, ADR_STAT, 8'h00);
    check("woken", 8'h20, rd & 8'h2e);
    xfer(1'b0, ADR_CTRL2, 8'h00);
    check("sleep_clear", 8'h0c, rd);
    xfer(1'b1, ADR_CTRL2, 8'h2c);
    repeat (2) @(posedge clk);
    check("irq_rx", 8'h01, {7'h0, irq});
    xfer(1'b0, ADR_DATA, 8'h00);
    check("addr_byte", 8'h81, rd);
    repeat (2) @(posedge clk);
    check("irq_clear", 8'h00, {7'h0, irq});
    $display("wakeup done");
    end_of_test();
  end
endmodule : asi_top_test
`default_nettype wire
